// ---- hdl/dbu_pkg.sv ----
// Shared constants and types for the delayed branch unit
package dbu_pkg;

    // ------------------------------------------------------------
    // Opcode fields
    // ------------------------------------------------------------
    localparam logic [3:0]  OP_SHORT_JUMP  = 4'hA;
    localparam logic [3:0]  OP_SHORT_CALL  = 4'hB;
    localparam logic [3:0]  OP_SYSTEM      = 4'h0;
    localparam logic [3:0]  OP_REG_GROUP   = 4'h4;
    localparam logic [7:0]  LOW_FAR_JUMP   = 8'h23;
    localparam logic [7:0]  LOW_FAR_CALL   = 8'h03;
    localparam logic [7:0]  LOW_REG_JUMP   = 8'h2B;
    localparam logic [7:0]  LOW_REG_CALL   = 8'h0B;
    localparam logic [15:0] CODE_RETURN    = 16'h000B;
    localparam logic [15:0] CODE_EXC_RET   = 16'h002B;
    localparam logic [7:0]  HI_COND_F      = 8'h8B;
    localparam logic [7:0]  HI_COND_T      = 8'h89;
    localparam logic [7:0]  HI_COND_FS     = 8'h8F;
    localparam logic [7:0]  HI_COND_TS     = 8'h8D;

    // ------------------------------------------------------------
    // Field positions and address constants
    // ------------------------------------------------------------
    localparam int          DISP_MSB       = 11;
    localparam int          REG_FIELD_LSB  = 8;
    localparam logic [31:0] PC_AHEAD       = 32'h0000_0004;
    localparam logic [31:0] HALF_ALIGN     = 32'hFFFF_FFFE;
    localparam logic [31:0] RESET_ADDR     = 32'h0000_0000;

    // Decoded instruction class
    typedef enum logic [2:0] {
        DBU_KIND_NONE,
        DBU_KIND_SHORT_JUMP,
        DBU_KIND_FAR_JUMP,
        DBU_KIND_SHORT_CALL,
        DBU_KIND_FAR_CALL,
        DBU_KIND_OTHER_BRANCH
    } dbu_kind_t;

    // Control sequence of the unit
    typedef enum logic [0:0] {
        DBU_ST_IDLE,
        DBU_ST_SLOT
    } dbu_state_t;

endpackage

// ---- hdl/dbu_dec_if.sv ----
// Interface carrying an instruction word and its decoded class
`timescale 1ns/100ps
interface dbu_dec_if;
    import dbu_pkg::*;
    logic [15:0] instr;
    dbu_kind_t   kind;
    logic [31:0] disp;

    modport decoder (input instr, output kind, output disp);
    modport user    (output instr, input kind, input disp);
endinterface

// ---- hdl/dbu_decode.sv ----
// Instruction class decoder for the delayed branch unit
`timescale 1ns/100ps
module dbu_decode
    import dbu_pkg::*;
(
    dbu_dec_if.decoder dec
);

    // ------------------------------------------------------------
    // Branches outside the four delayed forms
    // ------------------------------------------------------------
    function automatic logic other_branch(input logic [15:0] w);
        logic cond;
        logic regb;
        cond = (w[15:8] == HI_COND_F) || (w[15:8] == HI_COND_T) ||
               (w[15:8] == HI_COND_FS) || (w[15:8] == HI_COND_TS);
        regb = (w[15:12] == OP_REG_GROUP) &&
               ((w[7:0] == LOW_REG_JUMP) || (w[7:0] == LOW_REG_CALL));
        return cond || regb || (w == CODE_RETURN) || (w == CODE_EXC_RET);
    endfunction

    // Class decode, short forms by top nibble, far forms by low byte
    always_comb begin
        dec.kind = DBU_KIND_NONE;
        if (dec.instr[15:12] == OP_SHORT_JUMP) begin
            dec.kind = DBU_KIND_SHORT_JUMP; // RL2
        end else if (dec.instr[15:12] == OP_SHORT_CALL) begin
            dec.kind = DBU_KIND_SHORT_CALL; // RL7
        end else if (dec.instr[15:12] == OP_SYSTEM && dec.instr[7:0] == LOW_FAR_JUMP) begin
            dec.kind = DBU_KIND_FAR_JUMP; // RL5
        end else if (dec.instr[15:12] == OP_SYSTEM && dec.instr[7:0] == LOW_FAR_CALL) begin
            dec.kind = DBU_KIND_FAR_CALL; // RL9
        end else if (other_branch(dec.instr)) begin
            dec.kind = DBU_KIND_OTHER_BRANCH;
        end
    end

    // Sign extend from the top displacement bit, then double
    assign dec.disp = {{19{dec.instr[DISP_MSB]}}, dec.instr[DISP_MSB:0], 1'b0}; // RL15

endmodule

// ---- hdl/dbu_top.sv ----
// Delayed branch unit: decode, target, return address and slot control
`timescale 1ns/100ps

// Notes on behaviour
// RL1: Short jump: slot first, then PC plus displacement
// RL2: Short jump opcode 1010, two states
// RL3: PC is branch address plus four
// RL4: Far jump: PC plus full register value
// RL5: Far jump opcode 0000nnnn00100011, two states
// RL6: Short call saves PC, then jumps
// RL7: Short call opcode 1011, two states
// RL8: Far call saves PC, jumps register-relative
// RL9: Far call opcode 0000nnnn00000011, two states
// RL10: Slot instruction completes before control transfers
// RL11: Saved return address skips the slot
// RL12: Interrupts and address errors held across slot
// RL13: Branch in slot raises illegal slot
// RL14: Register target captured before slot writes
// RL15: Sign extend, double, keep halfword alignment
module dbu_top
    import dbu_pkg::*;
#(
    parameter int ADDR_W = 32
)(
    input  wire logic              i_ref_clk,
    input  wire logic              i_reset,
    input  wire logic              i_instr_valid,
    input  wire logic [15:0]       i_instr,
    input  wire logic [ADDR_W-1:0] i_instr_addr,
    input  wire logic [31:0]       i_reg_data,
    input  wire logic              i_irq_req,
    input  wire logic              i_addr_err_req,
    output logic                   o_branch_taken,
    output logic [ADDR_W-1:0]      o_branch_target,
    output logic                   o_pr_we,
    output logic [ADDR_W-1:0]      o_pr_data,
    output logic                   o_illegal_slot,
    output logic                   o_event_hold,
    output logic                   o_irq_accept,
    output logic                   o_addr_err_accept
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (ADDR_W != 32) begin : g_bad_width
        $error("dbu_top serves a 32-bit address only");
    end

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    dbu_dec_if dec ();
    dbu_state_t        state;
    logic [31:0]       pend_target;
    logic [31:0]       pc_ahead;
    logic [31:0]       next_target;
    logic              is_delayed;
    logic              slot_done;

    assign dec.instr = i_instr;

    dbu_decode dbu_decode_inst (
        .dec (dec)
    );

    // Branch address plus four is the base of every target
    assign pc_ahead = i_instr_addr + PC_AHEAD; // RL3

    assign is_delayed = (dec.kind == DBU_KIND_SHORT_JUMP) || (dec.kind == DBU_KIND_FAR_JUMP) ||
                        (dec.kind == DBU_KIND_SHORT_CALL) || (dec.kind == DBU_KIND_FAR_CALL);

    assign slot_done = (state == DBU_ST_SLOT) && i_instr_valid;

    // Target select; register form uses the value read with the branch
    always_comb begin
        next_target = pc_ahead + dec.disp; // RL1 RL6
        if (dec.kind == DBU_KIND_FAR_JUMP || dec.kind == DBU_KIND_FAR_CALL) begin
            next_target = (pc_ahead + i_reg_data) & HALF_ALIGN; // RL4 RL8 RL15
        end
    end

    // ------------------------------------------------------------
    // Sequence: issue cycle, then the slot
    // ------------------------------------------------------------
    // Hold flag moves with the state so events see it the same cycle
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            state        <= DBU_ST_IDLE;
            o_event_hold <= 1'b0;
        end else begin
            case (state)
                DBU_ST_IDLE: begin
                    if (i_instr_valid && is_delayed) begin
                        state        <= DBU_ST_SLOT; // RL2 RL5 RL7 RL9
                        o_event_hold <= 1'b1; // RL12
                    end
                end
                DBU_ST_SLOT: begin
                    if (i_instr_valid) begin
                        state        <= DBU_ST_IDLE;
                        o_event_hold <= 1'b0;
                    end
                end
                default: begin
                    state        <= DBU_ST_IDLE;
                    o_event_hold <= 1'b0;
                end
            endcase
        end
    end

    // Target latched at issue, so a slot write cannot move it
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            pend_target <= RESET_ADDR;
        end else if (state == DBU_ST_IDLE && i_instr_valid && is_delayed) begin
            pend_target <= next_target; // RL14
        end
    end

    // ------------------------------------------------------------
    // Return address write for the call forms
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_pr_we   <= 1'b0;
            o_pr_data <= RESET_ADDR;
        end else begin
            o_pr_we <= 1'b0;
            if (state == DBU_ST_IDLE && i_instr_valid &&
                (dec.kind == DBU_KIND_SHORT_CALL || dec.kind == DBU_KIND_FAR_CALL)) begin
                o_pr_we   <= 1'b1; // RL6 RL8
                o_pr_data <= pc_ahead; // RL11
            end
        end
    end

    // ------------------------------------------------------------
    // Redirect or illegal slot, once the slot instruction arrives
    // ------------------------------------------------------------
    // A branch in the slot is never run; the pending jump is dropped too
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_branch_taken  <= 1'b0;
            o_branch_target <= RESET_ADDR;
            o_illegal_slot  <= 1'b0;
        end else begin
            o_branch_taken <= 1'b0;
            o_illegal_slot <= 1'b0;
            if (slot_done) begin
                if (is_delayed || dec.kind == DBU_KIND_OTHER_BRANCH) begin
                    o_illegal_slot <= 1'b1; // RL13
                end else begin
                    o_branch_taken  <= 1'b1; // RL10
                    o_branch_target <= pend_target;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Event acceptance, blocked at issue and through the slot
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            o_irq_accept      <= 1'b0;
            o_addr_err_accept <= 1'b0;
        end else begin
            o_irq_accept      <= i_irq_req && state == DBU_ST_IDLE &&
                                 !(i_instr_valid && is_delayed); // RL12
            o_addr_err_accept <= i_addr_err_req && state == DBU_ST_IDLE &&
                                 !(i_instr_valid && is_delayed); // RL12
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);

    chk_short_jump_target: assert property ( // RL1
        state == DBU_ST_IDLE && i_instr_valid && i_instr[15:12] == 4'hA |=>
        state == DBU_ST_SLOT && pend_target == $past(i_instr_addr) + 32'h0000_0004 +
        {{19{$past(i_instr[11])}}, $past(i_instr[11:0]), 1'b0})
        else $error("short jump target wrong");

    chk_far_jump_target: assert property ( // RL4
        state == DBU_ST_IDLE && i_instr_valid && i_instr[15:12] == 4'h0 &&
        i_instr[7:0] == 8'h23 |=>
        pend_target == (($past(i_instr_addr) + 32'h0000_0004 + $past(i_reg_data)) &
        32'hFFFF_FFFE) && !o_pr_we)
        else $error("far jump target wrong");

    chk_short_call_pr: assert property ( // RL11
        state == DBU_ST_IDLE && i_instr_valid && i_instr[15:12] == 4'hB |=>
        o_pr_we && o_pr_data == $past(i_instr_addr) + 32'h0000_0004)
        else $error("short call return address wrong");

    chk_far_call_pr: assert property ( // RL8
        state == DBU_ST_IDLE && i_instr_valid && i_instr[15:12] == 4'h0 &&
        i_instr[7:0] == 8'h03 |=> o_pr_we && state == DBU_ST_SLOT)
        else $error("far call did not save return address");

    chk_slot_then_jump: assert property ( // RL10
        o_branch_taken |-> $past(slot_done) && o_branch_target == $past(pend_target))
        else $error("redirect without slot completion");

    chk_illegal_slot_flag: assert property ( // RL13
        slot_done && i_instr[15:12] == 4'hA |=> o_illegal_slot && !o_branch_taken)
        else $error("branch in slot not flagged");

    chk_events_held: assert property ( // RL12
        state == DBU_ST_SLOT |=> !o_irq_accept && !o_addr_err_accept)
        else $error("event accepted inside slot");

    chk_two_state_exec: assert property ( // RL2
        state == DBU_ST_IDLE && i_instr_valid && is_delayed ##1 i_instr_valid |=>
        state == DBU_ST_IDLE)
        else $error("delayed branch not complete in two states");

endmodule

// ---- verif/dbu_cpu_model.sv ----
// Behavioural instruction feed standing in for the CPU fetch and register file
`timescale 1ns/100ps
module dbu_cpu_model (
    input  wire logic        i_ref_clk,
    output logic             o_valid,
    output logic [15:0]      o_instr,
    output logic [31:0]      o_addr,
    output logic [31:0]      o_reg
);
    // ------------------------------------------------------------
    // Idle values at time zero
    // ------------------------------------------------------------
    initial begin
        o_valid = 1'b0;
        o_instr = 16'h0000;
        o_addr  = 32'h0000_0000;
        o_reg   = 32'h0000_0000;
    end

    // ------------------------------------------------------------
    // Feed tasks
    // ------------------------------------------------------------
    // Present one word; returns just after the edge that takes it
    task automatic issue(input logic [15:0] word, input logic [31:0] addr,
                         input logic [31:0] rdat);
        o_valid <= 1'b1;
        o_instr <= word;
        o_addr  <= addr;
        o_reg   <= rdat;
        @(posedge i_ref_clk);
    endtask

    // Stall cycles; buses toggle so a stale value can never pass as good
    task automatic idle(input int n);
        repeat (n) begin
            o_valid <= 1'b0;
            o_instr <= ~o_instr;
            o_addr  <= ~o_addr;
            o_reg   <= ~o_reg;
            @(posedge i_ref_clk);
        end
    endtask
endmodule

// ---- verif/dbu_top_bench.sv ----
// Self-checking bench for the delayed branch unit
`timescale 1ns/100ps
module dbu_top_bench;
    import dbu_pkg::*;
    logic        i_ref_clk, i_reset, irq, aerr;
    logic        valid;
    logic [15:0] instr;
    logic [31:0] addr, rdat;
    logic        o_branch_taken, o_pr_we, o_illegal_slot, o_event_hold;
    logic        o_irq_accept, o_addr_err_accept;
    logic [31:0] o_branch_target, o_pr_data;
    int          n_fail, total_checks;
    logic [15:0] slot_bad [12] = '{16'hA123, 16'hB000, 16'h0323, 16'h0403, 16'h8B00,
        16'h8900, 16'h8D00, 16'h8F00, 16'h4E2B, 16'h4E0B, 16'h000B, 16'h002B};

    dbu_cpu_model dbu_cpu_model_inst (.i_ref_clk(i_ref_clk), .o_valid(valid),
        .o_instr(instr), .o_addr(addr), .o_reg(rdat));
    dbu_top #(.ADDR_W(32)) dbu_top_inst (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
        .i_instr_valid(valid), .i_instr(instr), .i_instr_addr(addr), .i_reg_data(rdat),
        .i_irq_req(irq), .i_addr_err_req(aerr), .o_branch_taken(o_branch_taken),
        .o_branch_target(o_branch_target), .o_pr_we(o_pr_we), .o_pr_data(o_pr_data),
        .o_illegal_slot(o_illegal_slot), .o_event_hold(o_event_hold),
        .o_irq_accept(o_irq_accept), .o_addr_err_accept(o_addr_err_accept));

    // ------------------------------------------------------------
    // Clock, compare and verdict
    // ------------------------------------------------------------
    initial begin
        i_ref_clk = 1'b0;
        forever #12.5 i_ref_clk = ~i_ref_clk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Target worked out independently: PC is the branch address plus four
    function automatic logic [31:0] exp_target(input logic [15:0] w, input logic [31:0] a,
                                               input logic [31:0] r);
        logic [31:0] pc;
        pc = a + 32'h0000_0004;
        if (w[15:13] == 3'b101) return pc + {{19{w[11]}}, w[11:0], 1'b0};
        return (pc + r) & 32'hFFFF_FFFE;
    endfunction

    // ------------------------------------------------------------
    // One branch plus its slot, with optional stall before the slot
    // ------------------------------------------------------------
    task automatic pair(input logic [15:0] bw, input logic [31:0] a, input logic [31:0] r,
                        input logic [15:0] sw, input logic [31:0] sr, input int gap,
                        input logic bad);
        logic call;
        call = (bw[15:12] == 4'hB) || (bw[15:12] == 4'h0 && bw[7:0] == 8'h03);
        dbu_cpu_model_inst.issue(bw, a, r);
        #1;
        check("hold", o_event_hold, 1);
        check("accept_issue", {o_irq_accept, o_addr_err_accept}, 0);
        check("pr_we", o_pr_we, call);
        if (call) check("pr_data", o_pr_data, a + 32'h0000_0004);
        dbu_cpu_model_inst.idle(gap);
        #1;
        check("hold_gap", o_event_hold, 1);
        check("no_early", o_branch_taken, 0);
        dbu_cpu_model_inst.issue(sw, a + 32'h0000_0002, sr);
        #1;
        check("taken", o_branch_taken, !bad);
        check("illegal", o_illegal_slot, bad);
        check("hold_end", o_event_hold, 0);
        check("accept_slot", {o_irq_accept, o_addr_err_accept}, 0);
        if (!bad) check("target", o_branch_target, exp_target(bw, a, r));
        dbu_cpu_model_inst.idle(1);
        #1;
        check("pulse_end", {o_branch_taken, o_illegal_slot, o_pr_we}, 0);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic sc_reset();
        check("reset_flags", {o_branch_taken, o_pr_we, o_illegal_slot, o_event_hold}, 0);
        check("reset_target", o_branch_target, 0);
        check("reset_pr", o_pr_data, 0);
    endtask

    // Reach ends of the short form: +4094 and -4096
    task automatic sc_short_jump();
        pair(16'hA7FF, 32'h0000_1000, 32'h5555_5555, 16'h0009, 32'h0, 0, 1'b0);
        pair(16'hA800, 32'h0000_2000, 32'h0, 16'h0009, 32'h0, 2, 1'b0);
    endtask

    task automatic sc_short_call();
        pair(16'hB123, 32'h0000_4000, 32'h0, 16'h6343, 32'h0, 0, 1'b0);
        pair(16'hBFFF, 32'h0000_4100, 32'h0, 16'h0009, 32'h0, 1, 1'b0);
    endtask

    // Slot rewrites the register; the old value must steer the jump
    task automatic sc_far_forms();
        pair(16'h0523, 32'h0000_3000, 32'h0000_0101, 16'h7501, 32'hFFFF_0000, 0, 1'b0);
        pair(16'h0C03, 32'h8000_0000, 32'hFFFF_FF00, 16'h0009, 32'h1234_5678, 1, 1'b0);
    endtask

    task automatic sc_illegal();
        foreach (slot_bad[i]) begin
            pair(16'hA010, 32'h0000_0100, 32'h0, slot_bad[i], 32'h0, 0, 1'b1);
        end
        pair(16'h0E23, 32'h0000_0200, 32'h0000_0040, 16'h0009, 32'h0, 0, 1'b0);
    endtask

    // Reset inside a pair drops the pending jump; a plain branch issued idle does nothing
    task automatic sc_mid_reset();
        dbu_cpu_model_inst.issue(16'hA004, 32'h0000_0700, 32'h0);
        i_reset <= 1'b1;
        dbu_cpu_model_inst.idle(2);
        i_reset <= 1'b0;
        dbu_cpu_model_inst.issue(16'h8B00, 32'h0000_0702, 32'h0);
        #1;
        check("mid_reset_hold", o_event_hold, 0);
        check("mid_reset_drop", {o_branch_taken, o_illegal_slot}, 0);
        dbu_cpu_model_inst.idle(1);
        #1;
        check("mid_reset_idle", {o_branch_taken, o_illegal_slot, o_event_hold}, 0);
    endtask

    // Events held across the pair, accepted one cycle after it ends
    task automatic sc_events();
        irq  <= 1'b1;
        aerr <= 1'b1;
        pair(16'hA004, 32'h0000_0600, 32'h0, 16'h0009, 32'h0, 1, 1'b0);
        check("accept_after", {o_irq_accept, o_addr_err_accept}, 2'b11);
        irq  <= 1'b0;
        aerr <= 1'b0;
        dbu_cpu_model_inst.idle(2);
        #1;
        check("accept_drop", {o_irq_accept, o_addr_err_accept}, 0);
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        n_fail = 0;
        total_checks = 0;
        i_reset = 1'b1;
        irq = 1'b0;
        aerr = 1'b0;
        repeat (5) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        @(posedge i_ref_clk);
        #1;
        sc_reset();
        sc_short_jump();
        sc_short_call();
        sc_far_forms();
        sc_illegal();
        sc_mid_reset();
        sc_events();
        summarize();
    end

    initial begin
        repeat (3000) @(posedge i_ref_clk);
        n_fail++;
        $display("[FAIL] watchdog expired");
        summarize();
    end
endmodule
